// ### rtl/pm_guard_pkg.sv
package pm_guard_pkg;

    // ------------------------------------------------------------------
    // program space
    // ------------------------------------------------------------------
    localparam int          PC_W          = 15;
    localparam int          WORD_W        = 14;
    localparam logic [14:0] LAST_SMALL    = 15'h0fff;
    localparam logic [14:0] LAST_LARGE    = 15'h1fff;
    localparam logic [14:0] RESET_VECTOR  = 15'h0000;
    localparam logic [14:0] IRQ_VECTOR    = 15'h0004;
    localparam logic [14:0] STORE_SPAN    = 15'h007f;
    localparam logic [14:0] BOOT_END_111  = 15'h01ff;
    localparam logic [14:0] BOOT_END_110  = 15'h03ff;
    localparam logic [14:0] BOOT_END_101  = 15'h07ff;
    localparam logic [14:0] BOOT_END_100  = 15'h0fff;
    localparam logic [14:0] BOOT_END_011  = 15'h1fff;
    localparam logic [14:0] BOOT_END_MAX  = 15'h3fff;
    localparam int          PROG_SEL_BIT  = 15;

    // ------------------------------------------------------------------
    // nonvolatile address space
    // ------------------------------------------------------------------
    localparam logic [15:0] EE_LO         = 16'hf000;
    localparam logic [15:0] EE_HI         = 16'hf0ff;
    localparam logic [15:0] CFGW_LO       = 16'h8007;
    localparam logic [15:0] CFGW_HI       = 16'h800b;
    localparam logic [15:0] USER_HI       = 16'h7fff;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFF_CFG       = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_NVM_ADDR  = 8'h08;
    localparam logic [7:0]  OFF_NVM_DATA  = 8'h0c;
    localparam logic [7:0]  OFF_NVM_GO    = 8'h10;
    localparam logic [7:0]  OFF_PC        = 8'h14;

    localparam int          CFG_SIZE_LSB  = 0;
    localparam int          CFG_BOOT_DIS  = 3;
    localparam int          CFG_STORE_DIS = 4;
    localparam int          CFG_APP_WL    = 7;
    localparam int          CFG_BOOT_WL   = 8;
    localparam int          CFG_CONF_WL   = 9;
    localparam int          CFG_EE_WL     = 10;
    localparam int          CFG_STORE_WL  = 11;
    localparam int          CFG_LARGE     = 16;
    localparam logic [31:0] CFG_RESET     = 32'h0001_0f9f;
    localparam logic [31:0] CFG_WMASK     = 32'h0001_0f9f;

    localparam int          ST_FAULT      = 0;
    localparam int          ST_VIOL_N     = 1;
    localparam int          ST_REGION_LSB = 4;

    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    typedef enum logic [1:0] {RG_APP, RG_BOOT, RG_STORE} region_t;
    typedef enum logic [1:0] {IND_IDLE, IND_PROG, IND_DONE} ind_phase_t;

endpackage

// ### rtl/program_memory_partition_guard.sv
`timescale 1ns/1ps
// Summary of operation
// - fifteen-bit program counter, 32K by 14 space
// - addresses beyond implemented memory wrap around
// - small variant ends 0FFFh, large ends 1FFFh
// - reset fetches 0000h, interrupt vectors 0004h
// - pointer high bit 15 selects program memory
// - program read delivers low eight bits only
// - indirect writes never change program memory
// - program indirect read takes one extra cycle
// - separate fetch and data buses run concurrently
// - EEPROM reached only via control registers, F000h-F0FFh
// - both disables set: everything is application
// - boot region runs from zero to boot end
// - storage region is last 128 words
// - storage region is not executable when enabled
// - separate write lock per region
// - locked write leaves memory, sets write fault
// - bad fetch raises violation reset, clears flag
// - size select picks boot end, capped half
// - write locks are active low
module program_memory_partition_guard
    import pm_guard_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // axi4-lite slave
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // core program counter control
    input  wire logic        pc_step,
    input  wire logic        pc_load,
    input  wire logic [14:0] pc_load_addr,
    input  wire logic        irq_take,
    output logic [14:0]      fetch_addr,
    output logic             exec_violation_reset,
    // core indirect access port
    input  wire logic        ind_req,
    input  wire logic        ind_we,
    input  wire logic [15:0] ind_ptr,
    input  wire logic [7:0]  ind_wdata,
    output logic             ind_ack,
    output logic [7:0]       ind_rdata,
    // data memory side
    output logic             dmem_req,
    output logic             dmem_we,
    output logic [14:0]      dmem_addr,
    output logic [7:0]       dmem_wdata,
    input  wire logic [7:0]  dmem_rdata,
    // program memory data bus
    output logic [14:0]      pdata_addr,
    input  wire logic [13:0] pdata_rword,
    // nonvolatile write port
    output logic             nvm_wr,
    output logic [15:0]      nvm_wr_addr,
    output logic [13:0]      nvm_wr_data
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [14:0] pc;
        logic        aw_have;
        logic [7:0]  aw_addr;
        logic        w_have;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] cfg;
        logic        fault;
        logic        viol_n;
        region_t     last_region;
        logic [15:0] nvm_addr;
        logic [13:0] nvm_data;
        logic        nvm_wr;
        logic [15:0] nvm_wr_addr;
        logic [13:0] nvm_wr_data;
        logic        viol_rst;
        ind_phase_t  phase;
        logic [14:0] paddr;
        logic [7:0]  ind_rdata;
        logic        ind_ack;
    } state_t;

    state_t s_q;
    state_t s_d;

    localparam state_t STATE_RESET = '{
        pc:          RESET_VECTOR,
        cfg:         CFG_RESET,
        viol_n:      1'b1,
        last_region: RG_APP,
        phase:       IND_IDLE,
        default:     '0
    };

    // ------------------------------------------------------------------
    // partition decode
    // ------------------------------------------------------------------
    logic [14:0] last_addr;
    logic [14:0] half_end;
    logic [14:0] boot_sel_end;
    logic [14:0] boot_end;
    logic [14:0] store_lo;
    logic        boot_on;
    logic        store_on;

    always_comb begin
        last_addr = s_q.cfg[CFG_LARGE] ? LAST_LARGE : LAST_SMALL;
        half_end  = last_addr >> 1;
        unique case (s_q.cfg[CFG_SIZE_LSB +: 3])
            3'b111:  boot_sel_end = BOOT_END_111;
            3'b110:  boot_sel_end = BOOT_END_110;
            3'b101:  boot_sel_end = BOOT_END_101;
            3'b100:  boot_sel_end = BOOT_END_100;
            3'b011:  boot_sel_end = BOOT_END_011;
            default: boot_sel_end = BOOT_END_MAX;
        endcase
        // oversize selections fall back to half of the array
        boot_end = (boot_sel_end > half_end) ? half_end : boot_sel_end;
        store_lo = last_addr - STORE_SPAN;
        boot_on  = !s_q.cfg[CFG_BOOT_DIS];
        store_on = !s_q.cfg[CFG_STORE_DIS];
    end

    function automatic logic [14:0] wrap(input logic [14:0] a);
        wrap = a & last_addr;
    endfunction

    function automatic region_t region_of(input logic [14:0] a);
        logic [14:0] w;
        w = wrap(a);
        if (store_on && w >= store_lo) begin
            region_of = RG_STORE;
        end else if (boot_on && w <= boot_end) begin
            region_of = RG_BOOT;
        end else begin
            region_of = RG_APP;
        end
    endfunction

    // active-low locks, a zero refuses the write
    function automatic logic write_ok(input logic [15:0] a);
        if (a >= EE_LO && a <= EE_HI) begin
            write_ok = s_q.cfg[CFG_EE_WL];
        end else if (a >= CFGW_LO && a <= CFGW_HI) begin
            write_ok = s_q.cfg[CFG_CONF_WL];
        end else if (a <= USER_HI) begin
            unique case (region_of(a[14:0]))
                RG_BOOT:  write_ok = s_q.cfg[CFG_BOOT_WL];
                RG_STORE: write_ok = s_q.cfg[CFG_STORE_WL];
                RG_APP:   write_ok = s_q.cfg[CFG_APP_WL];
            endcase
        end else begin
            write_ok = 1'b0;
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~m) | (nw & m);
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic        wr_fire;
    logic        rd_fire;
    logic [31:0] wv;
    logic [31:0] cfg_new;
    logic        set_fault;
    logic        set_viol;
    logic        is_prog;

    always_comb begin
        s_d       = s_q;
        wv        = merge(32'h0000_0000, s_q.w_data, s_q.w_strb);
        cfg_new   = merge(s_q.cfg, s_q.w_data, s_q.w_strb) & CFG_WMASK;
        set_fault = 1'b0;
        set_viol  = 1'b0;
        is_prog   = ind_ptr[PROG_SEL_BIT];
        s_d.nvm_wr   = 1'b0;
        s_d.viol_rst = 1'b0;
        s_d.ind_ack  = 1'b0;

        // -------- program counter --------
        if (s_q.viol_rst) begin
            s_d.pc = RESET_VECTOR;
        end else if (irq_take) begin
            s_d.pc = IRQ_VECTOR;
        end else if (pc_load) begin
            s_d.pc = wrap(pc_load_addr);
        end else if (pc_step) begin
            s_d.pc = wrap(s_q.pc + 15'h0001);
        end
        if (pc_step && !s_q.viol_rst) begin
            s_d.last_region = region_of(s_q.pc);
            if (region_of(s_q.pc) == RG_STORE) begin
                set_viol     = 1'b1;
                s_d.viol_rst = 1'b1;
            end
        end

        // -------- write channel --------
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        if (wr_fire) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = RESP_OKAY;
            unique case (s_q.aw_addr)
                OFF_CFG: begin
                    // size select is frozen once the boot region is on
                    if (boot_on) begin
                        cfg_new[CFG_SIZE_LSB +: 3] =
                            s_q.cfg[CFG_SIZE_LSB +: 3];
                    end
                    s_d.cfg = cfg_new;
                end
                OFF_STATUS: begin
                    if (wv[ST_FAULT]) begin
                        s_d.fault = 1'b0;
                    end
                    if (wv[ST_VIOL_N]) begin
                        s_d.viol_n = 1'b1;
                    end
                end
                OFF_NVM_ADDR: s_d.nvm_addr = wv[15:0];
                OFF_NVM_DATA: s_d.nvm_data = wv[13:0];
                OFF_NVM_GO: begin
                    if (write_ok(s_q.nvm_addr)) begin
                        s_d.nvm_wr      = 1'b1;
                        s_d.nvm_wr_addr = s_q.nvm_addr;
                        s_d.nvm_wr_data = s_q.nvm_data;
                    end else begin
                        set_fault = 1'b1;
                    end
                end
                OFF_PC: ;
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end
        // hardware set wins over a same-cycle software clear
        if (set_fault) begin
            s_d.fault = 1'b1;
        end
        if (set_viol) begin
            s_d.viol_n = 1'b0;
        end

        // -------- read channel --------
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        rd_fire = s_axi_arvalid && s_axi_arready;
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            unique case (s_axi_araddr)
                OFF_CFG:      s_d.rdata = s_q.cfg;
                OFF_STATUS: begin
                    s_d.rdata[ST_FAULT]             = s_q.fault;
                    s_d.rdata[ST_VIOL_N]            = s_q.viol_n;
                    s_d.rdata[ST_REGION_LSB +: 2]   = s_q.last_region;
                end
                OFF_NVM_ADDR: s_d.rdata[15:0] = s_q.nvm_addr;
                OFF_NVM_DATA: s_d.rdata[13:0] = s_q.nvm_data;
                OFF_NVM_GO:   ;
                OFF_PC:       s_d.rdata[14:0] = s_q.pc;
                default:      s_d.rresp = RESP_SLVERR;
            endcase
        end

        // -------- indirect access --------
        unique case (s_q.phase)
            IND_IDLE: begin
                if (ind_req) begin
                    if (is_prog && !ind_we) begin
                        s_d.paddr = wrap(ind_ptr[14:0]);
                        s_d.phase = IND_PROG;
                    end else begin
                        // program-space writes are acked and dropped
                        s_d.ind_ack   = 1'b1;
                        s_d.ind_rdata = dmem_rdata;
                        s_d.phase     = IND_DONE;
                    end
                end
            end
            IND_PROG: begin
                s_d.ind_rdata = pdata_rword[7:0];
                s_d.ind_ack   = 1'b1;
                s_d.phase     = IND_DONE;
            end
            IND_DONE: s_d.phase = IND_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = !s_q.aw_have;
    assign s_axi_wready  = !s_q.w_have;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

    // fetch uses its own bus, so data reads never stall it
    assign fetch_addr    = s_q.pc;
    assign exec_violation_reset = s_q.viol_rst;

    assign ind_ack       = s_q.ind_ack;
    assign ind_rdata     = s_q.ind_rdata;
    assign dmem_req      = ind_req && s_q.phase == IND_IDLE && !is_prog;
    assign dmem_we       = ind_we;
    assign dmem_addr     = ind_ptr[14:0];
    assign dmem_wdata    = ind_wdata;
    assign pdata_addr    = s_q.paddr;

    assign nvm_wr        = s_q.nvm_wr;
    assign nvm_wr_addr   = s_q.nvm_wr_addr;
    assign nvm_wr_data   = s_q.nvm_wr_data;

endmodule

// ### test/pm_guard_properties.sv
`timescale 1ns/1ps
module pm_guard_properties
    import pm_guard_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        irq_take,
    input wire logic        pc_load,
    input wire logic [14:0] pc_load_addr,
    input wire logic [14:0] fetch_addr,
    input wire logic        exec_violation_reset,
    input wire logic        ind_req,
    input wire logic        ind_we,
    input wire logic [15:0] ind_ptr,
    input wire logic        ind_ack,
    input wire logic        dmem_req,
    input wire logic [14:0] pdata_addr,
    input wire logic        nvm_wr,
    input wire logic        s_axi_bvalid
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // low 12 bits are common to both variants, so one check fits both
    property load_p;
        pc_load && !irq_take && !exec_violation_reset
            |=> fetch_addr[11:0] == $past(pc_load_addr[11:0]);
    endproperty

    space_bound_a: assert property (fetch_addr[14:13] == 2'b00)
        else $error("fetch address outside space");
    data_bound_a: assert property (pdata_addr[14:13] == 2'b00)
        else $error("program data address not wrapped");
    irq_vector_a: assert property (irq_take && !exec_violation_reset
        |=> fetch_addr == IRQ_VECTOR) else $error("irq vector wrong");
    load_wrap_a: assert property (load_p)
        else $error("loaded address wrong");
    viol_pulse_a: assert property (exec_violation_reset
        |=> !exec_violation_reset) else $error("violation pulse long");
    viol_home_a: assert property (exec_violation_reset
        |-> ##[0:2] fetch_addr == RESET_VECTOR)
        else $error("violation did not restart");
    prog_path_a: assert property (ind_req && ind_ptr[PROG_SEL_BIT]
        |-> !dmem_req) else $error("program read hit data memory");
    prog_write_a: assert property (ind_req && ind_we && ind_ptr[15]
        |-> ##1 !nvm_wr ##1 !nvm_wr) else $error("program write stored");
    ack_pulse_a: assert property (ind_ack |=> !ind_ack)
        else $error("ack longer than one cycle");
    nvm_resp_a: assert property (nvm_wr |-> s_axi_bvalid
        ##1 !nvm_wr) else $error("nvm write pulse misplaced");

    cover property (irq_take);
    cover property (exec_violation_reset);
    cover property (nvm_wr);
    cover property (ind_req && ind_ptr[15]);
endmodule

bind program_memory_partition_guard pm_guard_properties
    pm_guard_properties_i (.*);

// ### test/pm_core_model.sv
`timescale 1ns/1ps
module pm_core_model (
    input  wire logic        clk_sys,
    input  wire logic        dmem_req,
    input  wire logic [14:0] dmem_addr,
    input  wire logic [14:0] pdata_addr,
    output logic [7:0]       dmem_rdata,
    output logic [13:0]      pdata_rword
);
    logic [7:0] last_q = 8'h00;
    // high address bits land in the low byte so wrap faults show
    assign pdata_rword = {pdata_addr[5:0], pdata_addr[13:6]} ^ 14'h01a5;
    // separate data bus; idle bus shows inverse of last value
    assign dmem_rdata = dmem_req ? (dmem_addr[7:0] ^ 8'h5a) : ~last_q;
    always @(posedge clk_sys) if (dmem_req) last_q <= dmem_rdata;
endmodule

// ### test/program_memory_partition_guard_tb.sv
`timescale 1ns/1ps
module program_memory_partition_guard_tb;
    import pm_guard_pkg::*;
    logic        clk_sys = 1'b0, rst = 1'b1;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, ind_wdata = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = '0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, dq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        pc_step = 1'b0, pc_load = 1'b0, irq_take = 1'b0;
    logic        ind_req = 1'b0, ind_we = 1'b0;
    logic [14:0] pc_load_addr = '0, fetch_addr, dmem_addr, pdata_addr;
    logic [15:0] ind_ptr = '0, nvm_wr_addr;
    logic [7:0]  ind_rdata, dmem_rdata, dmem_wdata, b;
    logic        exec_violation_reset, ind_ack, dmem_req, dmem_we, nvm_wr;
    logic [13:0] pdata_rword, nvm_wr_data;
    int          mismatches = 0, samples_checked = 0;
    int          viols = 0, nvms = 0, lat, e;
    logic [31:0] cfgs [6] = '{32'h0001_0f9f, 32'h0001_0f97, 32'h0001_0f97,
                              32'h0000_0f94, 32'h0000_0f94, 32'h0001_0f8f};
    logic [14:0] pcs [6] = '{15'h1fff, 15'h01ff, 15'h0200,
                             15'h07ff, 15'h0800, 15'h1f7f};
    logic [1:0]  rgs [6] = '{2'd0, 2'd1, 2'd0, 2'd1, 2'd0, 2'd0};
    logic [15:0] nads [5] = '{16'h0400, 16'h0100, 16'h8007,
                              16'hf010, 16'h1fc0};

    program_memory_partition_guard program_memory_partition_guard_i (.*);
    pm_core_model pm_core_model_i (.*);

    initial forever #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        viols <= viols + exec_violation_reset;
        nvms  <= nvms + nvm_wr;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ready is registered-derived, so the negedge value is the edge value
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tk;
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        tk = 1'b0;
        while (!tk) begin
            @(negedge clk_sys);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tk = s_axi_bvalid === 1'b1;
            rs = s_axi_bresp;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tk) s_axi_bready <= 1'b0;
        end
    endtask

    task automatic rdr(input logic [7:0] a);
        logic ta, tk;
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        tk = 1'b0;
        while (!tk) begin
            @(negedge clk_sys);
            ta = s_axi_arvalid && s_axi_arready;
            tk = s_axi_rvalid === 1'b1;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tk) s_axi_rready <= 1'b0;
        end
    endtask

    // k = {irq, load, step}; one-cycle pulse, pc read after it lands
    task automatic pcop(input logic [2:0] k, input logic [14:0] a);
        @(posedge clk_sys);
        {irq_take, pc_load, pc_step} <= k;
        pc_load_addr <= a;
        @(posedge clk_sys);
        {irq_take, pc_load, pc_step} <= 3'b000;
        @(negedge clk_sys);
    endtask

    task automatic at(input logic [14:0] a);
        pcop(3'b010, a);
        pcop(3'b001, '0);
        rdr(OFF_STATUS);
    endtask

    task automatic nv(input logic [15:0] a);
        e = nvms;
        wr(OFF_NVM_ADDR, {16'h0000, a});
        wr(OFF_NVM_DATA, 32'h0000_2abc);
        wr(OFF_NVM_GO, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        rdr(OFF_STATUS);
    endtask

    // two idle edges: the ack cycle itself refuses a new request
    task automatic ind(input logic we, input logic [15:0] p);
        logic tk;
        repeat (2) @(posedge clk_sys);
        ind_we    <= we;
        ind_ptr   <= p;
        ind_wdata <= 8'hc3;
        ind_req   <= 1'b1;
        tk = 1'b0;
        lat = 0;
        @(negedge clk_sys);
        dq = dmem_req;
        while (!tk) begin
            @(posedge clk_sys);
            ind_req <= 1'b0;
            @(negedge clk_sys);
            lat++;
            tk = ind_ack === 1'b1;
            b = ind_rdata;
        end
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        #1ms;
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        chk(fetch_addr, RESET_VECTOR);
        rdr(OFF_CFG);
        chk(rd, CFG_RESET);
        rdr(OFF_STATUS);
        chk(rd[5:0], 6'h02);
        wr(8'h18, 32'h0000_0001);
        chk(rs, RESP_SLVERR);
        rdr(8'h18);
        chk(rs, RESP_SLVERR);
        chk(rd, 32'h0000_0000);
        $display("registers done");
        pcop(3'b001, '0);
        chk(fetch_addr, 15'h0001);
        pcop(3'b100, '0);
        chk(fetch_addr, IRQ_VECTOR);
        pcop(3'b010, 15'h2abc);
        chk(fetch_addr, 15'h0abc);
        pcop(3'b011, 15'h0123);
        chk(fetch_addr, 15'h0123);
        rdr(OFF_PC);
        chk(rd, 32'h0000_0123);
        wr(OFF_CFG, 32'h0000_0f9f);
        pcop(3'b010, 15'h7234);
        chk(fetch_addr, 15'h0234);
        at(15'h0fff);
        chk(fetch_addr, 15'h0000);
        $display("program counter done");
        for (int i = 0; i < 6; i++) begin
            wr(OFF_CFG, cfgs[i] | 32'h8);
            wr(OFF_CFG, cfgs[i]);
            at(pcs[i]);
            chk(rd[5:4], rgs[i]);
        end
        chk(viols, 0);
        at(15'h1f80);
        chk(rd[1], 1'b0);
        chk(viols, 1);
        chk(fetch_addr, RESET_VECTOR);
        wr(OFF_STATUS, 32'h0000_0002);
        rdr(OFF_STATUS);
        chk(rd[1], 1'b1);
        $display("partition done");
        for (int i = 0; i < 5; i++) begin
            wr(OFF_CFG, 32'h0001_0f87 & ~(32'h1 << (7 + i)));
            nv(nads[i]);
            chk(nvms - e, 0);
            chk(rd[0], 1'b1);
            wr(OFF_STATUS, 32'h0000_0003);
            wr(OFF_CFG, 32'h0001_0f87);
            nv(nads[i]);
            chk(nvms - e, 1);
            chk(rd[0], 1'b0);
            chk(nvm_wr_addr, nads[i]);
        end
        chk(nvm_wr_data, 14'h2abc);
        rdr(OFF_NVM_ADDR);
        chk(rd, 32'h0000_1fc0);
        rdr(OFF_NVM_DATA);
        chk(rd, 32'h0000_2abc);
        nv(16'hf100);
        chk(nvms - e, 0);
        chk(rd[0], 1'b1);
        wr(OFF_STATUS, 32'h0000_0003);
        $display("write locks done");
        ind(1'b0, 16'h0123);
        chk(lat, 1);
        chk({dq, b}, {1'b1, 8'h23 ^ 8'h5a});
        chk({dmem_we, dmem_addr, dmem_wdata}, {1'b0, 15'h0123, 8'hc3});
        ind(1'b0, 16'h8123);
        chk(lat, 2);
        chk({dq, b}, {1'b0, 8'h04 ^ 8'ha5});
        ind(1'b0, 16'ha123);
        chk(b, 8'h04 ^ 8'ha5);
        e = nvms;
        ind(1'b1, 16'h8200);
        repeat (3) @(posedge clk_sys);
        chk(lat, 1);
        chk(dq, 1'b0);
        chk(nvms - e, 0);
        $display("indirect done");
        end_sim();
    end
endmodule
